// ==== logic/legacy_timer_pkg.sv ====
// Purpose: Shared constants and carrier types for the dual counter/timer
// Assumes: Single system clock, prescaled tick arrives as a one-cycle pulse
// Notes:   Mode codes follow the two-bit mode field layout
package legacy_timer_pkg;

   // Mode field encodings
   localparam logic [1:0] mode_13bit  = 2'h0;
   localparam logic [1:0] mode_16bit  = 2'h1;
   localparam logic [1:0] mode_reload = 2'h2;
   localparam logic [1:0] mode_idle   = 2'h3;

   // Count layout and reset values
   localparam int         low_field_width = 5;
   localparam logic [7:0] byte_reset      = 8'h00;
   localparam logic [7:0] byte_ones       = 8'hff;
   localparam logic [4:0] low5_ones       = 5'h1f;

   // Per-timer configuration
   typedef struct packed {
      logic [1:0] mode;
      logic       run_bit;
      logic       gate_control;
      logic       count_source_select;
      logic       fast_clock_select;
      logic       gate_polarity;
      logic       overflow_irq_enable;
   } timer_config_type;

   // Software write of the count bytes and flag
   typedef struct packed {
      logic       low_write;
      logic       high_write;
      logic [7:0] write_data;
      logic       flag_clear;
      logic       vector_ack;
   } timer_access_type;

   // Visible timer state
   typedef struct packed {
      logic [7:0] low_byte;
      logic [7:0] high_byte;
      logic       overflow_flag;
      logic       irq;
   } timer_status_type;

endpackage : legacy_timer_pkg

// ==== logic/legacy_timer_unit.sv ====
// Purpose: One counter/timer channel with event edge detect and modes
// Assumes: Event and gate pins synchronous to clk
// Notes:   Instantiated once for each timer
`timescale 1ns/10ps
`default_nettype none

module legacy_timer_unit (
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire logic                                clk_en,
   input  wire logic                                prescale_tick,
   input  wire logic                                event_pin,
   input  wire logic                                gate_input,
   input  wire legacy_timer_pkg::timer_config_type  cfg,
   input  wire legacy_timer_pkg::timer_access_type  acc,
   output legacy_timer_pkg::timer_status_type       status
);

   typedef struct packed {
      logic       event_prev;
      logic [7:0] low_byte;
      logic [7:0] high_byte;
      logic       overflow_flag;
      logic       irq;
   } unit_state_type;

   unit_state_type state;
   unit_state_type next_state;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic tick;
      logic enable;
      logic wrap;
      logic [7:0] low_inc;
      tick    = 1'b0;
      enable  = 1'b0;
      wrap    = 1'b0;
      low_inc = 8'h00;
      next_state = state;
      next_state.event_prev = event_pin;
      // Source choice among three clocks
      if (cfg.count_source_select) begin
         tick = state.event_prev & ~event_pin;              // see RULE2
      end else if (cfg.fast_clock_select) begin
         tick = 1'b1;                                       // see RULE3
      end else begin
         tick = prescale_tick;                              // see RULE1 RULE3 RULE19
      end
      // Gate qualifies run
      enable = cfg.run_bit &
               (~cfg.gate_control | (gate_input == cfg.gate_polarity)); // see RULE10 RULE11
      low_inc = state.low_byte + 8'h01;
      // Count, run never resets count
      if (enable && tick) begin                              // see RULE12
         unique case (cfg.mode)
            legacy_timer_pkg::mode_13bit: begin             // see RULE6 RULE17
               next_state.low_byte[4:0] = low_inc[4:0];
               if (state.low_byte[4:0] == legacy_timer_pkg::low5_ones) begin
                  next_state.high_byte = state.high_byte + 8'h01;
                  wrap = (state.high_byte == legacy_timer_pkg::byte_ones); // see RULE7
               end
            end
            legacy_timer_pkg::mode_16bit: begin             // see RULE8
               next_state.low_byte = low_inc;
               if (state.low_byte == legacy_timer_pkg::byte_ones) begin
                  next_state.high_byte = state.high_byte + 8'h01;
                  wrap = (state.high_byte == legacy_timer_pkg::byte_ones);
               end
            end
            legacy_timer_pkg::mode_reload: begin            // see RULE9
               if (state.low_byte == legacy_timer_pkg::byte_ones) begin
                  next_state.low_byte = state.high_byte;
                  wrap = 1'b1;
               end else begin
                  next_state.low_byte = low_inc;
               end
            end
            legacy_timer_pkg::mode_idle: begin
               wrap = 1'b0;                                 // Inactive, holds
            end
         endcase
      end
      // Software byte writes override counting
      if (acc.low_write) begin
         next_state.low_byte = acc.write_data;              // see RULE5
      end
      if (acc.high_write) begin
         next_state.high_byte = acc.write_data;             // see RULE5
      end
      // Set wins over software clear and vector clear
      if (wrap) begin
         next_state.overflow_flag = 1'b1;                   // see RULE7
      end else if (acc.flag_clear || acc.vector_ack) begin
         next_state.overflow_flag = 1'b0;                   // see RULE18
      end
      next_state.irq = next_state.overflow_flag & cfg.overflow_irq_enable; // see RULE14
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   assign status.low_byte      = state.low_byte;
   assign status.high_byte     = state.high_byte;
   assign status.overflow_flag = state.overflow_flag;
   assign status.irq           = state.irq;

endmodule : legacy_timer_unit

`default_nettype wire

// ==== logic/dual_legacy_counter_timer.sv ====
// Purpose: Two independent legacy counter/timers with overflow requests
// Assumes: All pins synchronous to clk; prescaled tick is a one-cycle pulse
// Notes:   Control bits are plain ports; no register bus
//
// Operation
// RULE1: Three count sources, tick, sysclk or event
// RULE2: Event mode counts falling event-pin edges
// RULE3: Timer mode uses sysclk or prescaled tick
// RULE4: Event levels last two cycles minimum
// RULE5: Sixteen-bit count accessed as two bytes
// RULE6: Thirteen-bit uses high byte, low five
// RULE7: Thirteen-bit wrap sets overflow flag
// RULE8: Sixteen-bit mode uses all bits
// RULE9: Reload mode reloads low from high
// RULE10: Count only when run and gate allow
// RULE11: Gate active level set by polarity
// RULE12: Setting run keeps the count value
// RULE13: Software preloads count before running
// RULE14: Interrupt when flag and enable set
// RULE15: Each timer has own mode field
// RULE16: Second timer identical with own bits
// RULE17: Mode codes 13, 16, reload, inactive
// RULE18: Flag cleared by software or vectoring
// RULE19: Prescaled tick is single-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none

module dual_legacy_counter_timer (
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire logic                                clk_en,
   input  wire logic                                prescale_tick,
   input  wire logic                                first_event_pin,
   input  wire logic                                second_event_pin,
   input  wire logic                                first_gate_input,
   input  wire logic                                second_gate_input,
   input  wire legacy_timer_pkg::timer_config_type  first_config,
   input  wire legacy_timer_pkg::timer_config_type  second_config,
   input  wire legacy_timer_pkg::timer_access_type  first_access,
   input  wire legacy_timer_pkg::timer_access_type  second_access,
   output legacy_timer_pkg::timer_status_type       first_status,
   output legacy_timer_pkg::timer_status_type       second_status
);

   ////////////////////////////////////////////////////////////////////////
   // Independent channels, each with own mode field
   legacy_timer_unit first_unit (                          // see RULE15
      .clk           (clk),
      .rst           (rst),
      .clk_en        (clk_en),
      .prescale_tick (prescale_tick),
      .event_pin     (first_event_pin),
      .gate_input    (first_gate_input),
      .cfg           (first_config),
      .acc           (first_access),
      .status        (first_status)
   );

   // Second channel, own pins and bits
   legacy_timer_unit second_unit (                         // see RULE16
      .clk           (clk),
      .rst           (rst),
      .clk_en        (clk_en),
      .prescale_tick (prescale_tick),
      .event_pin     (second_event_pin),
      .gate_input    (second_gate_input),
      .cfg           (second_config),
      .acc           (second_access),
      .status        (second_status)
   );

endmodule : dual_legacy_counter_timer

`default_nettype wire

// ==== testbench/event_source.sv ====
// Purpose: External event pin stand-in
// Assumes: Changes just after the rising clk edge
// Notes:   Idles high; each level lasts two cycles
`timescale 1ns/10ps
`default_nettype none
module event_source (
   input  wire logic clk,
   input  wire logic en,
   output logic      pin
);
   logic [1:0] phase;
   // Start in the high phase so the pin idles high
   initial phase = 2'h0;
   // Two high, two low: a quarter of clk at most
   always @(posedge clk) if (en) phase <= phase + 2'h1;
   assign pin = ~phase[1];
endmodule : event_source
`default_nettype wire

// ==== testbench/timer_sva.sv ====
// Purpose: Port checks for the dual counter/timer
// Assumes: clk_en may drop; every assertion is qualified by it
// Notes:   Bound onto the top module
`timescale 1ns/10ps
`default_nettype none
module timer_sva (
   input wire logic                              clk,
   input wire logic                              rst,
   input wire logic                              clk_en,
   input wire logic                              second_gate_input,
   input wire legacy_timer_pkg::timer_config_type first_config,
   input wire legacy_timer_pkg::timer_config_type second_config,
   input wire legacy_timer_pkg::timer_access_type first_access,
   input wire legacy_timer_pkg::timer_access_type second_access,
   input wire legacy_timer_pkg::timer_status_type first_status,
   input wire legacy_timer_pkg::timer_status_type second_status
);
   // Aliases; q no byte write, k free fast count
   wire legacy_timer_pkg::timer_config_type f = first_config;
   wire legacy_timer_pkg::timer_config_type g = second_config;
   wire legacy_timer_pkg::timer_status_type s = first_status;
   wire [15:0] w1 = {s.high_byte, s.low_byte};
   wire [15:0] w2 = {second_status.high_byte, second_status.low_byte};
   wire q1 = clk_en & ~first_access.low_write & ~first_access.high_write;
   wire q2 = clk_en & ~second_access.low_write & ~second_access.high_write;
   wire k1 = q1 & f.run_bit & ~f.gate_control & f.fast_clock_select & ~f.count_source_select;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   chk_count_sixteen: assert property (k1 && f.mode == 2'h1 |=> w1 == $past(w1) + 16'h1)
      else $error("16-bit step wrong");
   chk_wrap_sixteen: assert property (k1 && f.mode == 2'h1 && w1 == 16'hffff |=> s.overflow_flag)
      else $error("16-bit wrap flag missing");
   chk_wrap_thirteen: assert property (k1 && f.mode == 2'h0 && {w1[15:8], w1[4:0]} == 13'h1fff
      |=> s.overflow_flag && w1[15:8] == 8'h00 && w1[4:0] == 5'h00)
      else $error("13-bit wrap wrong");
   chk_reload_low: assert property (k1 && f.mode == 2'h2 && s.low_byte == 8'hff
      |=> s.low_byte == $past(s.high_byte) && s.overflow_flag && $stable(s.high_byte))
      else $error("reload wrong");
   chk_stopped_hold: assert property (q1 && !f.run_bit |=> $stable(w1))
      else $error("stopped timer moved");
   chk_idle_hold: assert property (q1 && f.mode == 2'h3 |=> $stable(w1))
      else $error("idle mode moved");
   chk_gate_hold: assert property (q2 && g.run_bit && g.gate_control
      && second_gate_input != g.gate_polarity |=> $stable(w2)) else $error("gated timer moved");
   chk_irq_flag: assert property (clk_en |=> s.irq == (s.overflow_flag && $past(f.overflow_irq_enable)))
      else $error("irq mismatch");
   chk_clear_flag: assert property (clk_en && first_access.flag_clear && !f.run_bit |=> !s.overflow_flag)
      else $error("flag not cleared");
   chk_write_low: assert property (clk_en && first_access.low_write
      |=> s.low_byte == $past(first_access.write_data)) else $error("low write lost");
   // Main scenarios reached
   cover property ($rose(s.irq));
   cover property (k1 && f.mode == 2'h2 && s.low_byte == 8'hff);
   cover property (q2 && g.run_bit && second_status.low_byte == 8'h05);
endmodule : timer_sva
bind dual_legacy_counter_timer timer_sva timer_sva_i (.clk(clk), .rst(rst), .clk_en(clk_en),
   .second_gate_input(second_gate_input), .first_config(first_config),
   .second_config(second_config), .first_access(first_access), .second_access(second_access),
   .first_status(first_status), .second_status(second_status));
`default_nettype wire

// ==== testbench/tb_dual_legacy_counter_timer.sv ====
// Purpose: Self-checking bench for the dual counter/timer
// Assumes: Inputs change on the falling clk edge
// Notes:   Config hex: mode, run, gate, source, fast, polarity, irq enable
`timescale 1ns/10ps
`default_nettype none
`define check(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_dual_legacy_counter_timer;
   logic clk = 0, rst = 1, tick = 0, ev_en = 0, ev, en = 1;
   logic [1:0] gate = 2'h3;
   legacy_timer_pkg::timer_config_type c [2] = '{8'h00, 8'h00};
   legacy_timer_pkg::timer_access_type a [2] = '{12'h000, 12'h000};
   legacy_timer_pkg::timer_status_type s [2];
   int bad_count = 0, compares = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   event_source event_source_i (.clk(clk), .en(ev_en), .pin(ev));
   dual_legacy_counter_timer dual_legacy_counter_timer_i (.clk(clk), .rst(rst), .clk_en(en),
      .prescale_tick(tick), .first_event_pin(ev), .second_event_pin(1'b1),
      .first_gate_input(gate[0]), .second_gate_input(gate[1]), .first_config(c[0]),
      .second_config(c[1]), .first_access(a[0]), .second_access(a[1]),
      .first_status(s[0]), .second_status(s[1]));
   ////////////////////////////////////////
   task automatic wr(input int t, input logic [7:0] lo, input logic [7:0] hi);
      @(negedge clk);
      a[t] = {2'h2, lo, 2'h0};
      @(negedge clk);
      a[t] = {2'h1, hi, 2'h0};
      @(negedge clk);
      a[t] = 12'h000;
   endtask : wr
   task automatic go(input int t, input int n);
      c[t].run_bit = 1'b1;
      repeat (n) @(negedge clk);
      c[t].run_bit = 1'b0;
   endtask : go
   task automatic pulse(input int t, input logic [11:0] v);
      a[t] = v;
      @(negedge clk);
      a[t] = 12'h000;
   endtask : pulse
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   // Watchdog
   initial begin
      repeat (2000) @(negedge clk);
      bad_count++;
      final_report();
   end
   // Test sequence
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `check("reset", 18'h00000, s[0])
      c[0] = 8'h45;
      wr(0, 8'hfe, 8'hff);
      go(0, 2);
      `check("wrap 16", 18'h00003, s[0])
      pulse(0, 12'h002);
      `check("flag clear", 18'h00000, s[0])
      c[0] = 8'h05;
      wr(0, 8'h1e, 8'hff);
      go(0, 2);
      `check("wrap 13", 14'h0001, {s[0].high_byte, s[0].low_byte[4:0], s[0].overflow_flag})
      pulse(0, 12'h001);
      `check("vector ack", 1'b0, s[0].overflow_flag)
      c[0] = 8'h85;
      wr(0, 8'hff, 8'hc0);
      go(0, 3);
      `check("reload", {8'hc2, 8'hc0, 2'h3}, s[0])
      pulse(0, 12'h002);
      c[0] = 8'hc5;
      go(0, 4);
      `check("idle", {8'hc2, 8'hc0, 2'h0}, s[0])
      c[0] = 8'h41;
      wr(0, 8'h00, 8'h00);
      c[0].run_bit = 1'b1;
      repeat (3) begin
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
         @(negedge clk);
      end
      c[0].run_bit = 1'b0;
      `check("prescale", 8'h03, s[0].low_byte)
      c[0] = 8'h49;
      wr(0, 8'h00, 8'h00);
      c[0].run_bit = 1'b1;
      ev_en = 1'b1;
      repeat (16) @(negedge clk);
      ev_en = 1'b0;
      go(0, 3);
      `check("events", 8'h04, s[0].low_byte)
      c[1] = 8'h54;
      wr(1, 8'h00, 8'h00);
      c[1].run_bit = 1'b1;
      repeat (4) @(negedge clk);
      `check("gated", 8'h00, s[1].low_byte)
      gate[1] = 1'b0;
      go(1, 5);
      `check("gate open", 8'h05, s[1].low_byte)
      en = 1'b0;
      go(1, 3);
      en = 1'b1;
      `check("frozen", 8'h05, s[1].low_byte)
      final_report();
   end
endmodule : tb_dual_legacy_counter_timer
`default_nettype wire
